/* pffs_consts.svh */
`ifndef PFFS_CONSTS_SVH
`define PFFS_CONSTS_SVH

// timing
`define PFFS_CLK_HZ 40000000
`define PFFS_SAMPLE_US 1000
`define PFFS_SAMPLE_CYC ((`PFFS_CLK_HZ / 1000000) * `PFFS_SAMPLE_US)

// register byte offsets
`define PFFS_OFS_CONV 6'h00
`define PFFS_OFS_MODE 6'h04
`define PFFS_OFS_CTRL 6'h08
`define PFFS_OFS_BUSFB1 6'h0c
`define PFFS_OFS_BUSFB2 6'h10
`define PFFS_OFS_SP1 6'h14
`define PFFS_OFS_SP2 6'h18
`define PFFS_OFS_ENTRY 6'h1c
`define PFFS_OFS_DCEIL 6'h20
`define PFFS_OFS_SMOOTH 6'h24
`define PFFS_OFS_FBOUT 6'h28
`define PFFS_OFS_REFOUT 6'h2c
`define PFFS_OFS_STATUS 6'h30

// field positions
`define PFFS_CTRL_CLAMP_BIT 0
`define PFFS_CTRL_CLOSED_BIT 1
`define PFFS_ST_STATE_LSB 0
`define PFFS_ST_ZONE2_BIT 2
`define PFFS_ST_WARN_BIT 3

// reset values
`define PFFS_RST_CONV 1'h0
`define PFFS_RST_MODE 4'h1
`define PFFS_RST_CLAMP 1'h1
`define PFFS_RST_CLOSED 1'h0
`define PFFS_RST_DCEIL 16'h0500
`define PFFS_RST_SMOOTH 4'h0

`endif

/* pffs_pkg.sv */
package pffs_pkg;

    typedef enum logic [3:0] {
        PFFS_MODE_MIN = 4'h0,
        PFFS_MODE_MAX = 4'h1,
        PFFS_MODE_SUM = 4'h2,
        PFFS_MODE_DIFF = 4'h3,
        PFFS_MODE_AVG = 4'h4,
        PFFS_MODE_ZMIN = 4'h5,
        PFFS_MODE_ZMAX = 4'h6,
        PFFS_MODE_FB1 = 4'h7,
        PFFS_MODE_FB2 = 4'h8
    } pffs_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RAMP,
        ST_RUN,
        ST_FROZEN
    } pffs_state_t;

endpackage : pffs_pkg

/* pffs_top.sv */
`include "pffs_consts.svh"
module pffs_top
    import pffs_pkg::*;
#(
    parameter int DW = 16,
    parameter int SAMPLE_CYC = `PFFS_SAMPLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // process inputs, same clock domain
    input wire logic signed [DW-1:0] ain1,
    input wire logic signed [DW-1:0] ain2,
    input wire logic signed [DW-1:0] remote_ref,
    input wire logic signed [DW-1:0] out_freq,
    input wire logic limit_hit,
    input wire logic start_cmd,
    input wire logic signed [DW-1:0] deriv_in,
    // regulator side
    output logic signed [DW-1:0] feedback_out,
    output logic signed [DW-1:0] reference_out,
    output logic signed [DW-1:0] deviation_out,
    output logic signed [DW-1:0] deriv_out,
    output logic reg_active,
    output logic integ_reload,
    output logic sample_valid
);

    localparam int CW = $clog2(SAMPLE_CYC);
    localparam int SW = $clog2(DW);

    if (DW < 8 || DW > 16) begin : g_bad_dw
        $error("pffs_top: DW must be 8..16");
    end
    if (SAMPLE_CYC < 2) begin : g_bad_cyc
        $error("pffs_top: SAMPLE_CYC must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic signed [DW-1:0] sat(input logic signed [DW:0] s);
        if (s[DW] != s[DW-1]) begin
            return s[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
        end
        return s[DW-1:0];
    endfunction : sat

    function automatic logic signed [DW-1:0] sadd(input logic signed [DW-1:0] a,
                                                  input logic signed [DW-1:0] b,
                                                  input logic neg);
        logic signed [DW:0] ea;
        logic signed [DW:0] eb;
        ea = {a[DW-1], a};
        eb = {b[DW-1], b};
        return sat(neg ? ea - eb : ea + eb);
    endfunction : sadd

    // full-scale preserving root: sqrt(x * 2^(DW-1)), negatives read as zero
    function automatic logic signed [DW-1:0] sroot(input logic signed [DW-1:0] x);
        logic [2*DW-1:0] v;
        logic [DW-1:0] r;
        logic [DW-1:0] t;
        v = '0;
        r = '0;
        t = '0;
        if (!x[DW-1]) begin
            v = (2*DW)'(x) << (DW-1);
            for (int i = DW-2; i >= 0; i--) begin
                t = r | (DW'(1) << i);
                if ((2*DW)'(t) * (2*DW)'(t) <= v) begin
                    r = t;
                end
            end
        end
        return r;
    endfunction : sroot

    function automatic logic [31:0] bemerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return m;
    endfunction : bemerge

    function automatic logic [31:0] sext(input logic signed [DW-1:0] x);
        return 32'(signed'(x));
    endfunction : sext

    ////////////////////////////////////////////////////////////////////////////
    // register file and bus slave

    logic waitreq_r, waitreq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic conv_r, conv_nxt;
    logic [3:0] mode_r, mode_nxt;
    logic clamp_en_r, clamp_en_nxt;
    logic closed_r, closed_nxt;
    logic signed [DW-1:0] bus1_r, bus1_nxt, bus2_r, bus2_nxt;
    logic signed [DW-1:0] sp1_r, sp1_nxt, sp2_r, sp2_nxt;
    logic signed [DW-1:0] entry_r, entry_nxt, ceil_r, ceil_nxt;
    logic [SW-1:0] smooth_r, smooth_nxt;
    logic signed [DW-1:0] comb_r, filt_r, ref_r, dev_r, dout_r;
    logic zone2_r;
    pffs_state_t state_r, state_nxt;

    logic [31:0] status_w;
    logic [31:0] wmerged;
    logic wr_go;

    assign status_w = {28'h0, conv_r & (mode_r == 4'h5 || mode_r == 4'h6),
                       zone2_r, state_r};
    assign wr_go = avs_write && !waitreq_r;

    function automatic logic [31:0] rd_mux(input logic [5:0] a);
        unique case (a)
            `PFFS_OFS_CONV: return {31'h0, conv_r};
            `PFFS_OFS_MODE: return {28'h0, mode_r};
            `PFFS_OFS_CTRL: return {30'h0, closed_r, clamp_en_r};
            `PFFS_OFS_BUSFB1: return sext(bus1_r);
            `PFFS_OFS_BUSFB2: return sext(bus2_r);
            `PFFS_OFS_SP1: return sext(sp1_r);
            `PFFS_OFS_SP2: return sext(sp2_r);
            `PFFS_OFS_ENTRY: return sext(entry_r);
            `PFFS_OFS_DCEIL: return sext(ceil_r);
            `PFFS_OFS_SMOOTH: return 32'(smooth_r);
            `PFFS_OFS_FBOUT: return sext(filt_r);
            `PFFS_OFS_REFOUT: return sext(ref_r);
            `PFFS_OFS_STATUS: return status_w;
            default: return 32'h0;
        endcase
    endfunction : rd_mux

    always_comb begin
        waitreq_nxt = !((avs_read || avs_write) && waitreq_r);
        rdata_nxt = rdata_r;
        if (avs_read && waitreq_r) begin
            rdata_nxt = rd_mux(avs_address);
        end
        conv_nxt = conv_r;
        mode_nxt = mode_r;
        clamp_en_nxt = clamp_en_r;
        closed_nxt = closed_r;
        bus1_nxt = bus1_r;
        bus2_nxt = bus2_r;
        sp1_nxt = sp1_r;
        sp2_nxt = sp2_r;
        entry_nxt = entry_r;
        ceil_nxt = ceil_r;
        smooth_nxt = smooth_r;
        wmerged = bemerge(rd_mux(avs_address), avs_writedata, avs_byteenable);
        if (wr_go) begin
            unique case (avs_address)
                `PFFS_OFS_CONV: conv_nxt = wmerged[0];
                `PFFS_OFS_MODE: begin
                    // unknown codes are dropped, the mode keeps its value
                    if (wmerged[3:0] <= 4'h8) begin
                        mode_nxt = wmerged[3:0];
                    end
                end
                `PFFS_OFS_CTRL: begin
                    clamp_en_nxt = wmerged[`PFFS_CTRL_CLAMP_BIT];
                    closed_nxt = wmerged[`PFFS_CTRL_CLOSED_BIT];
                end
                `PFFS_OFS_BUSFB1: bus1_nxt = wmerged[DW-1:0];
                `PFFS_OFS_BUSFB2: bus2_nxt = wmerged[DW-1:0];
                `PFFS_OFS_SP1: sp1_nxt = wmerged[DW-1:0];
                `PFFS_OFS_SP2: sp2_nxt = wmerged[DW-1:0];
                `PFFS_OFS_ENTRY: entry_nxt = wmerged[DW-1:0];
                // negative ceiling would invert the clamp
                `PFFS_OFS_DCEIL: ceil_nxt = wmerged[DW-1] ? '0 : wmerged[DW-1:0];
                `PFFS_OFS_SMOOTH: smooth_nxt = wmerged[SW-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitreq_r <= 1'b1;
            rdata_r <= 32'h0;
            conv_r <= `PFFS_RST_CONV;
            mode_r <= `PFFS_RST_MODE;
            clamp_en_r <= `PFFS_RST_CLAMP;
            closed_r <= `PFFS_RST_CLOSED;
            bus1_r <= '0;
            bus2_r <= '0;
            sp1_r <= '0;
            sp2_r <= '0;
            entry_r <= '0;
            ceil_r <= DW'(`PFFS_RST_DCEIL);
            smooth_r <= SW'(`PFFS_RST_SMOOTH);
        end else begin
            waitreq_r <= waitreq_nxt;
            rdata_r <= rdata_nxt;
            conv_r <= conv_nxt;
            mode_r <= mode_nxt;
            clamp_en_r <= clamp_en_nxt;
            closed_r <= closed_nxt;
            bus1_r <= bus1_nxt;
            bus2_r <= bus2_nxt;
            sp1_r <= sp1_nxt;
            sp2_r <= sp2_nxt;
            entry_r <= entry_nxt;
            ceil_r <= ceil_nxt;
            smooth_r <= smooth_nxt;
        end
    end

    assign avs_waitrequest = waitreq_r;
    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // sample datapath, runs regardless of loop mode

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic tick;
    logic valid_r, valid_nxt;
    logic signed [DW-1:0] fb1_c, fb2_c, d1_c, d2_c, comb_c, ref_c, sp_c, filt_c;
    logic signed [DW:0] avg_c, fdiff_c, fsum_c;
    logic zone2_c;
    logic signed [DW-1:0] comb_nxt, filt_nxt, ref_nxt, dev_nxt, dout_nxt;
    logic zone2_nxt;

    assign tick = (cnt_r == '0);

    always_comb begin
        fb1_c = sadd(bus1_r, ain1, 1'b0);
        fb2_c = sadd(bus2_r, ain2, 1'b0);
        if (conv_r) begin
            fb1_c = sroot(fb1_c);
            fb2_c = sroot(fb2_c);
        end
        d1_c = sadd(sp1_r, fb1_c, 1'b1);
        d2_c = sadd(sp2_r, fb2_c, 1'b1);
        avg_c = ({fb1_c[DW-1], fb1_c} + {fb2_c[DW-1], fb2_c}) >>> 1;
        zone2_c = 1'b0;
        comb_c = fb1_c;
        unique case (mode_r)
            PFFS_MODE_MIN: comb_c = (fb1_c < fb2_c) ? fb1_c : fb2_c;
            PFFS_MODE_MAX: comb_c = (fb1_c > fb2_c) ? fb1_c : fb2_c;
            PFFS_MODE_SUM: comb_c = sadd(fb1_c, fb2_c, 1'b0);
            PFFS_MODE_DIFF: comb_c = sadd(fb2_c, fb1_c, 1'b1);
            PFFS_MODE_AVG: comb_c = avg_c[DW-1:0];
            PFFS_MODE_ZMIN: zone2_c = (d2_c > d1_c);
            PFFS_MODE_ZMAX: zone2_c = (d2_c < d1_c);
            PFFS_MODE_FB1: comb_c = fb1_c;
            PFFS_MODE_FB2: zone2_c = 1'b1;
            default: comb_c = fb1_c;
        endcase
        if (zone2_c) begin
            comb_c = fb2_c;
        end
        // setpoint two only ever reaches the sum through a zone pick
        sp_c = zone2_c ? sp2_r : sp1_r;
        ref_c = sadd(remote_ref, sp_c, 1'b0);
        // y += (x - y) >> k: time constant about 2^k samples
        fdiff_c = {comb_c[DW-1], comb_c} - {filt_r[DW-1], filt_r};
        // both operands signed, or the shift would fill zeros on a falling input
        fsum_c = signed'({filt_r[DW-1], filt_r}) + (fdiff_c >>> smooth_r);
        filt_c = fsum_c[DW-1:0];
    end

    always_comb begin
        cnt_nxt = tick ? CW'(SAMPLE_CYC - 1) : cnt_r - CW'(1);
        valid_nxt = tick;
        comb_nxt = comb_r;
        filt_nxt = filt_r;
        ref_nxt = ref_r;
        dev_nxt = dev_r;
        zone2_nxt = zone2_r;
        if (tick) begin
            comb_nxt = comb_c;
            filt_nxt = filt_c;
            ref_nxt = ref_c;
            dev_nxt = sadd(ref_c, filt_c, 1'b1);
            zone2_nxt = zone2_c;
        end
        // clamp both directions on the ceiling
        if (deriv_in > ceil_r) begin
            dout_nxt = ceil_r;
        end else if (deriv_in < -ceil_r) begin
            dout_nxt = -ceil_r;
        end else begin
            dout_nxt = deriv_in;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            valid_r <= 1'b0;
            comb_r <= '0;
            filt_r <= '0;
            ref_r <= '0;
            dev_r <= '0;
            zone2_r <= 1'b0;
            dout_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            valid_r <= valid_nxt;
            comb_r <= comb_nxt;
            filt_r <= filt_nxt;
            ref_r <= ref_nxt;
            dev_r <= dev_nxt;
            zone2_r <= zone2_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign feedback_out = filt_r;
    assign reference_out = ref_r;
    assign deviation_out = dev_r;
    assign deriv_out = dout_r;
    assign sample_valid = valid_r;

    ////////////////////////////////////////////////////////////////////////////
    // start-up and anti-windup sequencer

    logic active_r, active_nxt;
    logic reload_r, reload_nxt;
    logic frz_sign_r, frz_sign_nxt;

    always_comb begin
        state_nxt = state_r;
        reload_nxt = 1'b0;
        frz_sign_nxt = frz_sign_r;
        if (!start_cmd || !closed_r) begin
            state_nxt = ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: state_nxt = ST_RAMP;
                ST_RAMP: begin
                    if (out_freq >= entry_r) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (limit_hit && clamp_en_r) begin
                        state_nxt = ST_FROZEN;
                        reload_nxt = 1'b1;
                        frz_sign_nxt = dev_r[DW-1];
                    end
                end
                ST_FROZEN: begin
                    // switching clamping off releases the hold at once
                    if (!clamp_en_r || dev_r == '0 || dev_r[DW-1] != frz_sign_r) begin
                        state_nxt = ST_RUN;
                    end
                end
            endcase
        end
        active_nxt = (state_nxt == ST_RUN);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            active_r <= 1'b0;
            reload_r <= 1'b0;
            frz_sign_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            active_r <= active_nxt;
            reload_r <= reload_nxt;
            frz_sign_r <= frz_sign_nxt;
        end
    end

    assign reg_active = active_r;
    assign integ_reload = reload_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_reload_entry: assert property (
        state_r == ST_RUN && start_cmd && closed_r && limit_hit && clamp_en_r
        |=> integ_reload && !reg_active && state_r == ST_FROZEN)
        else $error("no reload at limit");
    a_clamp_off: assert property (!clamp_en_r |=> !integ_reload)
        else $error("reload while clamping off");
    a_entry_hold: assert property (
        state_r == ST_RAMP && out_freq < entry_r |=> !reg_active)
        else $error("regulator active below entry frequency");
    a_deriv_clamp: assert property (
        deriv_in > ceil_r |=> deriv_out == $past(ceil_r))
        else $error("derivative not clamped");
    a_filter_pass: assert property (
        tick && smooth_r == '0 |=> feedback_out == comb_r)
        else $error("unsmoothed filter differs");
    a_min_pick: assert property (
        tick && mode_r == 4'h0 |=> comb_r <= $past(fb1_c) && comb_r <= $past(fb2_c))
        else $error("minimum mode wrong");
    a_sp2_zone: assert property (
        tick && zone2_c |-> mode_r inside {4'h5, 4'h6, 4'h8})
        else $error("setpoint two outside zone modes");
    a_frozen_exit: assert property (
        state_r == ST_FROZEN && start_cmd && closed_r && dev_r == '0
        |=> state_r == ST_RUN ##0 reg_active)
        else $error("frozen hold not released");
    a_sample_spacing: assert property (
        sample_valid |=> !sample_valid [*1] ##0 cnt_r == CW'(SAMPLE_CYC - 2))
        else $error("sample period wrong");
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not one cycle");

    c_frozen: cover property (state_r == ST_RUN ##1 state_r == ST_FROZEN);
    c_zone2: cover property (tick && zone2_c && mode_r == 4'h5);
    c_root: cover property (tick && conv_r && mode_r == 4'h7);
    c_read: cover property (avs_read && !avs_waitrequest);

endmodule : pffs_top

/* tb.sv */
`include "pffs_consts.svh"
module tb
    import pffs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // short sample period keeps the run brief
    localparam int SC = 8;
    logic clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic signed [15:0] ain1, ain2, remote_ref, out_freq, deriv_in;
    logic signed [15:0] feedback_out, reference_out, deviation_out, deriv_out;
    logic limit_hit, start_cmd, reg_active, integ_reload, sample_valid;
    logic signed [15:0] b1, b2, a1, a2, s1, s2, rr, ef, er, dv;
    int err_total, n_tests, p;

    pffs_top #(.DW(16), .SAMPLE_CYC(SC)) pffs_top_i (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ain1(ain1),
        .ain2(ain2), .remote_ref(remote_ref), .out_freq(out_freq), .limit_hit(limit_hit),
        .start_cmd(start_cmd), .deriv_in(deriv_in), .feedback_out(feedback_out),
        .reference_out(reference_out), .deviation_out(deviation_out),
        .deriv_out(deriv_out), .reg_active(reg_active), .integ_reload(integ_reload),
        .sample_valid(sample_valid));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // called at an edge; holds the request until waitrequest is sampled low
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        // read data stands at the accepting edge; a hang is left to the watchdog
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task wr(input logic [5:0] a, input logic signed [15:0] d);
        bus(1'b1, a, {{16{d[15]}}, d});
    endtask : wr

    task rc(input string nm, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rc

    // returns at the edge that samples the second pulse; checks the period
    task wsv2;
        do @(posedge clk); while (sample_valid !== 1'b1);
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while (sample_valid !== 1'b1);
        chk("period", SC, p);
    endtask : wsv2

    task cnt(input int n);
        p = 0;
        repeat (n) begin
            @(posedge clk);
            if (integ_reload === 1'b1) p++;
        end
    endtask : cnt

    function automatic logic signed [15:0] rnd();
        return 16'($urandom_range(2000)) - 16'sh03e8;
    endfunction : rnd

    function automatic void model(input int m, input logic signed [15:0] f1, f2, s1, s2, rr,
                                  output logic signed [15:0] fb, rf);
        logic z2;
        z2 = (m == 5) ? ((s2 - f2) > (s1 - f1)) : ((s2 - f2) < (s1 - f1));
        fb = f1;
        rf = rr + s1;
        case (m)
            0: fb = (f1 < f2) ? f1 : f2;
            1: fb = (f1 > f2) ? f1 : f2;
            2: fb = f1 + f2;
            3: fb = f2 - f1;
            4: fb = (f1 + f2) >>> 1;
            5, 6: if (z2) begin fb = f2; rf = rr + s2; end
            8: begin fb = f2; rf = rr + s2; end
            default: ;
        endcase
    endfunction : model

    function automatic logic signed [15:0] dclamp(input logic signed [15:0] d);
        logic signed [15:0] c;
        c = `PFFS_RST_DCEIL;
        return (d > c) ? c : ((d < -c) ? -c : d);
    endfunction : dclamp

////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("MISMATCH watchdog expected finish seen timeout");
        close_out;
    end

    initial begin
        {resetn, avs_read, avs_write, limit_hit, start_cmd} = 5'h00;
        {avs_address, avs_writedata, avs_byteenable} = {6'h00, 32'h0, 4'hf};
        {ain1, ain2, remote_ref, out_freq, deriv_in} = {5{16'h0000}};
        void'($urandom(32'h2589859c));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rc("conv", `PFFS_OFS_CONV, 32'h0);
        rc("mode", `PFFS_OFS_MODE, 32'h1);
        rc("ctrl", `PFFS_OFS_CTRL, 32'h1);
        rc("dceil", `PFFS_OFS_DCEIL, 32'h500);
        wr(`PFFS_OFS_MODE, 16'h0009);
        rc("mode", `PFFS_OFS_MODE, 32'h1);
        wr(6'h34, 16'h1234);
        rc("unmapped", 6'h34, 32'h0);
        wr(`PFFS_OFS_SP1, 16'sh1111);
        avs_byteenable <= 4'h2;
        wr(`PFFS_OFS_SP1, 16'sh2222);
        avs_byteenable <= 4'hf;
        rc("lanes", `PFFS_OFS_SP1, 32'h00002211);
        wr(`PFFS_OFS_DCEIL, 16'sh8000);
        rc("dceil_neg", `PFFS_OFS_DCEIL, 32'h0);
        wr(`PFFS_OFS_DCEIL, `PFFS_RST_DCEIL);
        $display("test registers done");
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 9; m++) begin
                {b1, b2, a1, a2, s1, s2, rr} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
                wr(`PFFS_OFS_MODE, 16'(m));
                wr(`PFFS_OFS_BUSFB1, b1);
                wr(`PFFS_OFS_BUSFB2, b2);
                wr(`PFFS_OFS_SP1, s1);
                wr(`PFFS_OFS_SP2, s2);
                ain1 <= a1;
                ain2 <= a2;
                remote_ref <= rr;
                wsv2;
                model(m, b1 + a1, b2 + a2, s1, s2, rr, ef, er);
                chk("fb_ref", {ef, er}, {feedback_out, reference_out});
                chk("deviation", er - ef, deviation_out);
                @(posedge clk);
            end
        end
        wr(`PFFS_OFS_MODE, 16'h0002);
        wr(`PFFS_OFS_BUSFB1, 16'sh4e20);
        wr(`PFFS_OFS_BUSFB2, 16'sh4e20);
        ain1 <= 16'sh2710;
        ain2 <= 16'sh2710;
        wsv2;
        chk("sum_sat", 16'h7fff, feedback_out);
        @(posedge clk);
        wr(`PFFS_OFS_CONV, 16'h0001);
        wr(`PFFS_OFS_MODE, 16'h0007);
        wr(`PFFS_OFS_BUSFB1, 16'sh2000);
        ain1 <= 16'sh0000;
        wsv2;
        chk("root", 16'h4000, feedback_out);
        rc("fbout", `PFFS_OFS_FBOUT, 32'h4000);
        rc("status", `PFFS_OFS_STATUS, 32'h0);
        // quarter step with k=2: a falling input must shift in sign bits
        wr(`PFFS_OFS_SMOOTH, 16'h0002);
        do @(posedge clk); while (sample_valid !== 1'b1);
        wr(`PFFS_OFS_CONV, 16'h0000);
        do @(posedge clk); while (sample_valid !== 1'b1);
        chk("smooth1", 16'h3800, feedback_out);
        do @(posedge clk); while (sample_valid !== 1'b1);
        chk("smooth2", 16'h3200, feedback_out);
        wr(`PFFS_OFS_SMOOTH, 16'h0000);
        $display("test feedback done");
        for (int i = 0; i < 24; i++) begin
            dv = (i < 4) ? 16'sh04ff + 16'(i) : 16'($urandom_range(8000)) - 16'sh0fa0;
            deriv_in <= (i % 2) ? -dv : dv;
            repeat (2) @(posedge clk);
            chk("deriv", dclamp((i % 2) ? -dv : dv), deriv_out);
        end
        $display("test derivative done");
        // deviation stays at +400 so the frozen state cannot clear by itself
        wr(`PFFS_OFS_CONV, 16'h0000);
        wr(`PFFS_OFS_BUSFB1, 16'h0000);
        wr(`PFFS_OFS_SP1, 16'sh01f4);
        wr(`PFFS_OFS_ENTRY, 16'sh0064);
        wr(`PFFS_OFS_CTRL, 16'h0003);
        {ain1, remote_ref, out_freq} <= {16'sh0064, 16'sh0000, 16'sh0032};
        start_cmd <= 1'b1;
        cnt(3 * SC);
        chk("active_early", 1'b0, reg_active);
        @(posedge clk);
        out_freq <= 16'sh00c8;
        cnt(4);
        chk("active", 1'b1, reg_active);
        @(posedge clk);
        limit_hit <= 1'b1;
        cnt(6);
        chk("reload", 1, p);
        chk("frozen", 1'b0, reg_active);
        // release by a zero deviation
        limit_hit <= 1'b0;
        ain1 <= 16'sh01f4;
        cnt(2 * SC + 2);
        chk("resume_zero", 1'b1, reg_active);
        // freeze on a negative deviation, release by a sign change
        ain1 <= 16'sh0258;
        cnt(2 * SC + 2);
        limit_hit <= 1'b1;
        cnt(6);
        chk("reload_neg", 1, p);
        chk("frozen_neg", 1'b0, reg_active);
        ain1 <= 16'sh0064;
        limit_hit <= 1'b0;
        cnt(2 * SC + 2);
        chk("resume", 1'b1, reg_active);
        wr(`PFFS_OFS_CTRL, 16'h0002);
        limit_hit <= 1'b1;
        cnt(3 * SC);
        chk("no_reload", 0, p);
        chk("still_active", 1'b1, reg_active);
        $display("test sequencer done");
        close_out;
    end
endmodule : tb
